//--- rtl/tpc_pkg.sv
/*
  Shared constants and types for the paper-tape punch cycle control pair.
  Assumes a single 100 MHz system clock shared by both ends.
*/
package tpc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ARM_DELAY_NS = 500;
  localparam int MIN_PULSE_NS = 5000;
  // least times round up to whole cycles
  localparam int ARM_CYCLES = (ARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARM_CNT_W = 6;
  localparam int PULSE_CNT_W = 10;
  localparam logic [ARM_CNT_W-1:0] ARM_LAST = ARM_CNT_W'(ARM_CYCLES - 1);
  localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = PULSE_CNT_W'(PULSE_CYCLES - 1);
  localparam logic [PULSE_CNT_W-1:0] QUIET_DONE = PULSE_CNT_W'(PULSE_CYCLES);

  localparam int DATA_W = 8;
  localparam int CH5_IDX = 4;
  typedef logic [DATA_W-1:0] tpc_data_t;

  // synchroniser lane positions on the device end
  localparam int SI_START = 0;
  localparam int SI_SHAFT = 1;
  localparam int SI_MEDIA_N = 2;
  localparam int SI_MANUAL_N = 3;
  localparam int SI_CH5_SEL_N = 4;
  localparam int SI_CARD_IN = 5;
  localparam int SI_CARD_HOLE = 6;
  localparam int SI_EXT_BUSY = 7;
  localparam int SI_DATA_STRAP = 8;
  localparam int SI_SPR_STRAP = 9;
  localparam int SI_CH5_STRAP = 10;
  localparam int SYNC_W = 11;
  // active-low lanes rest high so reset does not fake a fault or manual feed
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h01C;

  typedef enum logic [1:0] {
    TPC_DEV_IDLE = 2'b00,
    TPC_DEV_ARM = 2'b01,
    TPC_DEV_FEED = 2'b11
  } tpc_dev_state_t;

  typedef enum logic [1:0] {
    TPC_SRC_IDLE = 2'b00,
    TPC_SRC_QUIET = 2'b01,
    TPC_SRC_PULSE = 2'b11
  } tpc_src_state_t;

  // register map of the source end, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DATA = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam int CTRL_FWD_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_FWD_BIT = 2;
  localparam logic CTRL_FWD_RST = 1'b1;
  localparam tpc_data_t DATA_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HRESP_OKAY = 2'b00;
endpackage : tpc_pkg

//--- rtl/tpc_link_if.sv
/*
  Punch handshake between the data source and the punch control.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface tpc_link_if;
  logic start_req;
  logic feed_fwd;
  tpc_pkg::tpc_data_t data;
  logic cycle_active;

  modport dev (input start_req, input feed_fwd, input data, output cycle_active);
  modport src (output start_req, output feed_fwd, output data, input cycle_active);
endinterface : tpc_link_if

//--- rtl/tpc_device.sv
/*
  Punch cycle control: turns cycle requests from the data source into
  forward feed, reverse feed, sprocket and data punch commands.
  Assumes solenoid drivers sit outside; shaft timing is a square wave
  whose rising edge is 0 degrees and falling edge 180 degrees.
*/
// Contract
// RULE1 - start cycle on request rising edge only
// RULE2 - source waits five us idle before request
// RULE3 - requests spaced at least five us apart
// RULE4 - source pulses last at least five us
// RULE5 - cycle active high busy, low ready
// RULE6 - cycle active is internal OR external busy
// RULE7 - media fault low forces cycle active
// RULE8 - direction high forward, low reverse
// RULE9 - direction changes only while idle
// RULE10 - data punching only in forward feed
// RULE11 - eight channels, punch each high channel
// RULE12 - data valid by 100 us, held
// RULE13 - manual advance low makes leader, no data
// RULE14 - strap fitted enables; else high inhibits
// RULE15 - leader punches channel five when selected
// RULE16 - prepunched card suppresses sprocket unless strapped
// RULE17 - card hole hold inhibits data, keeps feeding
// RULE18 - arm feed and punch after 0.5 us
// RULE19 - feed state clears at feed drive end
// RULE20 - manual advance feeds continuously with sprockets
// RULE21 - synchronise inputs and detect edges
`timescale 1ns/10ps
module tpc_device (
  tpc_link_if.dev LINK,
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SHAFT_TIMING,
  input wire logic MEDIA_FAULT_N,
  input wire logic EXT_BUSY,
  input wire logic MANUAL_ADVANCE_N,
  input wire logic CH5_FILL_SEL_N,
  input wire logic CARD_IN_POSITION,
  input wire logic CARD_HOLE_HOLD,
  input wire logic DATA_STRAP,
  input wire logic SPROCKET_HOLE_STRAP,
  input wire logic CH5_FILL_STRAP,
  output logic FWD_FEED,
  output logic REV_FEED,
  output logic SPROCKET_PUNCH,
  output tpc_pkg::tpc_data_t DATA_PUNCH
);
  import tpc_pkg::*;

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction : rose

  function automatic logic fell(input logic now, input logic was);
    fell = ~now & was;
  endfunction : fell

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] sync_c;
  logic start_rise;
  logic shaft_rise;
  logic shaft_fall;
  logic manual_on;
  logic hold_on;
  logic data_ok;
  logic sprocket_ok;
  logic ch5_fill;
  logic dir_fwd;
  logic feed_end;
  tpc_dev_state_t state;
  tpc_dev_state_t next_state;
  logic [ARM_CNT_W-1:0] arm_cnt;
  logic punch_en;
  logic fwd;
  logic rev;
  tpc_data_t next_data;

  assign raw = {CH5_FILL_STRAP, SPROCKET_HOLE_STRAP, DATA_STRAP, EXT_BUSY, CARD_HOLE_HOLD,
                CARD_IN_POSITION, CH5_FILL_SEL_N, MANUAL_ADVANCE_N, MEDIA_FAULT_N,
                SHAFT_TIMING, LINK.start_req};

  // the third stage only feeds edge detection; sync_a is read by sync_b alone
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
      sync_c <= SYNC_RST;
    end else begin
      sync_a <= raw; // RULE21
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign start_rise = rose(sync_b[SI_START], sync_c[SI_START]); // RULE1
  assign shaft_rise = rose(sync_b[SI_SHAFT], sync_c[SI_SHAFT]); // RULE21
  assign shaft_fall = fell(sync_b[SI_SHAFT], sync_c[SI_SHAFT]); // RULE21

  assign manual_on = ~sync_b[SI_MANUAL_N]; // RULE13
  // a strap fitted keeps the function on whatever the inhibit input does
  assign data_ok = sync_b[SI_DATA_STRAP] | ~sync_b[SI_CARD_HOLE]; // RULE14
  assign sprocket_ok = sync_b[SI_SPR_STRAP] | ~sync_b[SI_CARD_IN]; // RULE16
  assign ch5_fill = sync_b[SI_CH5_STRAP] | ~sync_b[SI_CH5_SEL_N]; // RULE15
  // a card hole hold with no data strap fitted keeps the feed state alive until the input drops
  assign hold_on = manual_on | ~data_ok; // RULE17
  // leader always runs forward
  assign dir_fwd = LINK.feed_fwd | manual_on; // RULE8
  assign feed_end = (fwd & shaft_fall) | (rev & shaft_rise);

  always_comb begin
    next_state = state;
    case (state)
      TPC_DEV_IDLE: begin
        if (start_rise) begin
          next_state = TPC_DEV_ARM; // RULE1
        end
      end
      TPC_DEV_ARM: begin
        if (arm_cnt == ARM_LAST) begin
          next_state = TPC_DEV_FEED; // RULE18
        end
      end
      TPC_DEV_FEED: begin
        if (feed_end && !hold_on) begin
          next_state = TPC_DEV_IDLE; // RULE19
        end
      end
      default: begin
        next_state = TPC_DEV_IDLE;
      end
    endcase
    if (hold_on) begin
      next_state = TPC_DEV_FEED; // RULE20
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= TPC_DEV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      arm_cnt <= '0;
    end else if (state == TPC_DEV_ARM) begin
      arm_cnt <= arm_cnt + ARM_CNT_W'(1); // RULE18
    end else begin
      arm_cnt <= '0;
    end
  end

  // like the original punch enable it stays set after a cycle and is dropped
  // only by manual feed; that is what tells leader from data cycles
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      punch_en <= 1'b0;
    end else if (manual_on) begin
      punch_en <= 1'b0; // RULE13
    end else if (state == TPC_DEV_ARM && arm_cnt == ARM_LAST) begin
      punch_en <= 1'b1; // RULE18
    end
  end

  // forward drive runs from 0 to 180 degrees, reverse from 180 to 360
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fwd <= 1'b0;
    end else if (fwd && shaft_fall) begin
      fwd <= 1'b0; // RULE19
    end else if (shaft_rise && state == TPC_DEV_FEED && dir_fwd) begin
      fwd <= 1'b1; // RULE8
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rev <= 1'b0;
    end else if (rev && shaft_rise) begin
      rev <= 1'b0; // RULE19
    end else if (shaft_fall && state == TPC_DEV_FEED && !dir_fwd) begin
      rev <= 1'b1; // RULE8
    end
  end

  always_comb begin
    next_data = '0;
    if (fwd && punch_en && LINK.feed_fwd && data_ok && !manual_on) begin
      next_data = LINK.data; // RULE10 RULE11 RULE17
    end
    if (fwd && !punch_en && ch5_fill) begin
      next_data[CH5_IDX] = 1'b1; // RULE15
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DATA_PUNCH <= '0;
      SPROCKET_PUNCH <= 1'b0;
    end else begin
      DATA_PUNCH <= next_data;
      SPROCKET_PUNCH <= fwd & sprocket_ok; // RULE16 RULE20
    end
  end

  assign FWD_FEED = fwd;
  assign REV_FEED = rev;

  // busy covers arming too, so the source never sees a ready gap mid-cycle
  assign LINK.cycle_active = (state != TPC_DEV_IDLE) // RULE5
                           | sync_b[SI_EXT_BUSY] // RULE6
                           | ~sync_b[SI_MEDIA_N]; // RULE7
endmodule : tpc_device

//--- rtl/tpc_source.sv
/*
  Data source end: an AHB-Lite slave whose registers set direction and
  data and launch punch cycles on the link with the required timing.
  Assumes one AHB-Lite master on CLK; the slave never inserts wait states.
*/
`timescale 1ns/10ps
module tpc_source (
  tpc_link_if.src LINK,
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic [1:0] HRESP
);
  import tpc_pkg::*;

  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic ctrl_fwd;
  tpc_data_t data_reg;
  logic go;
  logic launch;
  tpc_src_state_t state;
  tpc_src_state_t next_state;
  logic [PULSE_CNT_W-1:0] cnt;

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a);
    rd_word = WORD_ZERO;
    case (a)
      REG_CTRL: rd_word[CTRL_FWD_BIT] = ctrl_fwd;
      REG_DATA: rd_word[DATA_W-1:0] = data_reg;
      REG_STATUS: begin
        rd_word[STAT_ACTIVE_BIT] = LINK.cycle_active;
        rd_word[STAT_PEND_BIT] = (state != TPC_SRC_IDLE);
        rd_word[STAT_FWD_BIT] = LINK.feed_fwd;
      end
      default: rd_word = WORD_ZERO;
    endcase
  endfunction : rd_word

  // hsize is not checked: only whole-word transfers are supported
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      HRDATA <= WORD_ZERO;
    end else if (HREADY) begin
      wr_pend <= HSEL & HTRANS[1] & HWRITE;
      wr_addr <= HADDR[ADDR_W-1:0];
      HRDATA <= (HSEL && HTRANS[1] && !HWRITE) ? rd_word(HADDR[ADDR_W-1:0]) : WORD_ZERO;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_fwd <= CTRL_FWD_RST;
      data_reg <= DATA_RST;
    end else if (wr_pend) begin
      if (wr_addr == REG_CTRL) begin
        ctrl_fwd <= HWDATA[CTRL_FWD_BIT];
      end
      if (wr_addr == REG_DATA) begin
        data_reg <= HWDATA[DATA_W-1:0];
      end
    end
  end

  // a go while a launch is pending is dropped
  assign go = wr_pend && wr_addr == REG_CTRL && HWDATA[CTRL_GO_BIT];
  assign launch = (state == TPC_SRC_QUIET) && (cnt == QUIET_DONE) && !LINK.cycle_active;

  always_comb begin
    next_state = state;
    case (state)
      TPC_SRC_IDLE: begin
        if (go) begin
          next_state = TPC_SRC_QUIET;
        end
      end
      TPC_SRC_QUIET: begin
        if (launch) begin
          next_state = TPC_SRC_PULSE; // RULE2 RULE3
        end
      end
      TPC_SRC_PULSE: begin
        if (cnt == PULSE_LAST) begin
          next_state = TPC_SRC_IDLE; // RULE4
        end
      end
      default: begin
        next_state = TPC_SRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= TPC_SRC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // in quiet the count is of consecutive idle cycles; any busy restarts it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= '0;
    end else if (state != next_state || (state == TPC_SRC_QUIET && LINK.cycle_active)) begin
      cnt <= '0; // RULE2
    end else if (cnt != QUIET_DONE) begin
      cnt <= cnt + PULSE_CNT_W'(1);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK.start_req <= 1'b0;
    end else begin
      LINK.start_req <= (next_state == TPC_SRC_PULSE); // RULE4
    end
  end

  // direction and data change only at launch, when the link is idle, and
  // then stand until the next launch, long after busy has fallen
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK.feed_fwd <= CTRL_FWD_RST;
      LINK.data <= DATA_RST;
    end else if (launch) begin
      LINK.feed_fwd <= ctrl_fwd; // RULE9
      LINK.data <= data_reg; // RULE12
    end
  end
endmodule : tpc_source

//--- verification/tpc_props.sv
/*
  Checker for the punch handshake between the source and device ends.
  Assumes it sits beside the link interface and shares its clock and reset.
*/
`timescale 1ns/10ps
module tpc_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic start_req,
  input wire logic feed_fwd,
  input wire tpc_pkg::tpc_data_t data,
  input wire logic cycle_active
);
  import tpc_pkg::*;
  int idle_cnt;
  int hi_cnt;
  int lo_cnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // counters saturate so a long idle run cannot wrap
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) idle_cnt <= 0;
    else if (cycle_active) idle_cnt <= 0;
    else if (idle_cnt < 4000) idle_cnt <= idle_cnt + 1;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) hi_cnt <= 0;
    else if (!start_req) hi_cnt <= 0;
    else if (hi_cnt < 4000) hi_cnt <= hi_cnt + 1;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) lo_cnt <= 0;
    else if (start_req) lo_cnt <= 0;
    else if (lo_cnt < 4000) lo_cnt <= lo_cnt + 1;
  end
  property p_ack; $rose(start_req) |-> ##[2:4] cycle_active; endproperty
  a_ack: assert property (p_ack) else $error("no busy after request");
  property p_arm; $rose(start_req) |-> ##4 cycle_active [*8]; endproperty
  a_arm: assert property (p_arm) else $error("busy dropped while arming");
  property p_quiet; $rose(start_req) |-> idle_cnt > 500; endproperty
  a_quiet: assert property (p_quiet) else $error("request too soon after busy");
  property p_space; $rose(start_req) |-> lo_cnt >= 500; endproperty
  a_space: assert property (p_space) else $error("requests too close");
  property p_width; $fell(start_req) |-> hi_cnt >= 500; endproperty
  a_width: assert property (p_width) else $error("request pulse too short");
  property p_dir; $changed(feed_fwd) |-> $rose(start_req) && !cycle_active; endproperty
  a_dir: assert property (p_dir) else $error("direction changed while busy");
  property p_pair; $changed(data) |-> $rose(start_req); endproperty
  a_pair: assert property (p_pair) else $error("data changed off launch");
  property p_hold; cycle_active |-> $stable(data); endproperty
  a_hold: assert property (p_hold) else $error("data changed while busy");
  c_fwd: cover property ($rose(start_req) && feed_fwd);
  c_rev: cover property ($rose(start_req) && !feed_fwd);
  c_done: cover property ($fell(cycle_active));
endmodule : tpc_props

//--- verification/tb_tape_punch_cycle_control.sv
/*
  Testbench joining the source and device ends over the link interface.
  Assumes a 100 MHz clock and a shaft wave made here with a 6 us period.
*/
`timescale 1ns/10ps
module tb_tape_punch_cycle_control;
  import tpc_pkg::*;
  localparam int B_FWD = 1;
  localparam int B_REV = 2;
  localparam int B_ACT = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic shaft = 1'b0;
  logic media_n = 1'b1;
  logic ext_busy = 1'b0;
  logic manual_n = 1'b1;
  logic sel_n = 1'b1;
  logic card_in = 1'b0;
  logic hole = 1'b0;
  logic dstrap = 1'b0;
  logic sstrap = 1'b0;
  logic cstrap = 1'b0;
  logic fwd_feed;
  logic rev_feed;
  logic spr;
  tpc_data_t punch;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic [1:0] hresp;
  logic hwrite = 1'b0;
  logic hready;
  logic [3:0] mon;
  int err_total = 0;
  int checks_done = 0;
  tpc_link_if tpc_link_if_i ();
  assign mon = {tpc_link_if_i.cycle_active, rev_feed, fwd_feed, 1'b0};
  always #5 clk = ~clk;
  always begin
    repeat (300) @(posedge clk);
    shaft <= ~shaft;
  end
  tpc_device tpc_device_i (.LINK(tpc_link_if_i.dev), .CLK(clk), .RST_N(rst_n), .SHAFT_TIMING(shaft),
    .MEDIA_FAULT_N(media_n), .EXT_BUSY(ext_busy), .MANUAL_ADVANCE_N(manual_n), .CH5_FILL_SEL_N(sel_n),
    .CARD_IN_POSITION(card_in), .CARD_HOLE_HOLD(hole), .DATA_STRAP(dstrap), .SPROCKET_HOLE_STRAP(sstrap),
    .CH5_FILL_STRAP(cstrap), .FWD_FEED(fwd_feed), .REV_FEED(rev_feed), .SPROCKET_PUNCH(spr),
    .DATA_PUNCH(punch));
  tpc_source tpc_source_i (.LINK(tpc_link_if_i.src), .CLK(clk), .RST_N(rst_n), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));
  tpc_props tpc_props_i (.CLK(clk), .RST_N(rst_n), .start_req(tpc_link_if_i.start_req),
    .feed_fwd(tpc_link_if_i.feed_fwd), .data(tpc_link_if_i.data), .cycle_active(tpc_link_if_i.cycle_active));
  task conclude();
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // bounded wait on one monitored level; read data settles before return
  task wt(input int b, input logic v);
    int n;
    n = 0;
    while (mon[b] !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 5000), 32'h1);
    #1;
  endtask : wt
  task ahb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    haddr <= 32'(a);
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, WORD_ZERO, r);
    chk(r, e);
    chk(32'(hresp), 32'(HRESP_OKAY));
  endtask : rd
  task regs();
    rd(REG_CTRL, 32'h1);
    rd(REG_DATA, 32'h0);
    rd(REG_STATUS, 32'h4);
    wr(4'hC, 32'hFF);
    rd(4'hC, 32'h0);
    wr(REG_DATA, 32'h1A5);
    rd(REG_DATA, 32'hA5);
  endtask : regs
  task flt(input logic m, input logic x);
    @(posedge clk);
    media_n <= m;
    ext_busy <= x;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(mon[B_ACT]), 32'h1);
    rd(REG_STATUS, 32'h5);
    @(posedge clk);
    media_n <= 1'b1;
    ext_busy <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(mon[B_ACT]), 32'h0);
  endtask : flt
  // o = {card in place, sprocket strap, card hole hold, data strap}
  task run_cyc(input logic fw, input tpc_data_t d, input logic [3:0] o, input tpc_data_t ed, input logic es);
    int b;
    logic held;
    logic bad;
    b = fw ? B_FWD : B_REV;
    held = o[1] & ~o[0];
    wr(REG_DATA, 32'(d));
    wr(REG_CTRL, {30'h0, 1'b1, fw});
    wt(B_ACT, 1'b1);
    // a card hold starts feeding by itself, so options go on once the cycle runs
    @(posedge clk);
    {card_in, sstrap, hole, dstrap} <= o;
    wt(b, 1'b1);
    @(posedge clk);
    #1;
    chk(32'(fw ? rev_feed : fwd_feed), 32'h0);
    chk(32'(punch), 32'(ed));
    chk(32'(spr), 32'(es));
    if (held) begin
      wt(b, 1'b0);
      wt(b, 1'b1);
      chk(32'(mon[B_ACT]), 32'h1);
    end
    @(posedge clk);
    {card_in, sstrap, hole, dstrap} <= 4'h0;
    wt(b, 1'b0);
    if (!held) begin
      repeat (2) @(posedge clk);
      #1;
      chk(32'(mon[B_ACT]), 32'h0);
    end
    wt(B_ACT, 1'b0);
    // the falling edge of the request must not start another cycle
    bad = 1'b0;
    repeat (700) begin
      @(posedge clk);
      if (mon[B_ACT] !== 1'b0) bad = 1'b1;
    end
    chk(32'(bad), 32'h0);
    rd(REG_STATUS, {29'h0, fw, 2'b00});
  endtask : run_cyc
  task man(input logic s, input logic c, input tpc_data_t e);
    @(posedge clk);
    manual_n <= 1'b0;
    sel_n <= s;
    cstrap <= c;
    repeat (2) begin
      wt(B_FWD, 1'b0);
      wt(B_FWD, 1'b1);
      @(posedge clk);
      #1;
      chk(32'(punch), 32'(e));
      chk(32'(spr), 32'h1);
    end
    @(posedge clk);
    manual_n <= 1'b1;
    sel_n <= 1'b1;
    cstrap <= 1'b0;
    wt(B_ACT, 1'b0);
  endtask : man
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    regs();
    flt(1'b0, 1'b0);
    flt(1'b1, 1'b1);
    run_cyc(1'b1, 8'hA5, 4'h0, 8'hA5, 1'b1);
    run_cyc(1'b0, 8'hFF, 4'h0, 8'h00, 1'b0);
    run_cyc(1'b1, 8'h3C, 4'h8, 8'h3C, 1'b0);
    run_cyc(1'b1, 8'h3C, 4'hC, 8'h3C, 1'b1);
    run_cyc(1'b1, 8'h5A, 4'h2, 8'h00, 1'b1);
    run_cyc(1'b1, 8'h5A, 4'h3, 8'h5A, 1'b1);
    man(1'b0, 1'b0, 8'h10);
    man(1'b1, 1'b0, 8'h00);
    man(1'b1, 1'b1, 8'h10);
    run_cyc(1'b1, 8'hC3, 4'h0, 8'hC3, 1'b1);
    conclude();
  end
endmodule : tb_tape_punch_cycle_control
